/* File: verilog/asr_top.sv */
`timescale 1ns/1ps

module asr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = DEPTH[AW:0];

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             rdy_q, rdy_d;
    logic             push, pop;

    assign push      = in_valid && rdy_q;
    assign pop       = out_valid && out_ready;
    assign in_ready  = rdy_q;
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rp_q];

    // pointers wrap naturally; depth must be a power of two
    always_comb begin
        wp_d  = wp_q;
        rp_d  = rp_q;
        cnt_d = cnt_q;
        if (push) begin
            wp_d = wp_q + 1'b1;
        end
        if (pop) begin
            rp_d = rp_q + 1'b1;
        end
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        if (flush) begin
            wp_d  = '0;
            rp_d  = '0;
            cnt_d = '0;
        end
        rdy_d = (cnt_d != FULL);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end
endmodule : asr_fifo

module asr_top #(
    parameter logic [7:0]  ID_VALUE = 8'h02,      // arbitrary value
    parameter logic [23:0] FSC_RST  = 24'h500000
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          sclk,
    input  wire logic          din,
    input  wire logic          sync_n,
    output logic               dout_rdy,
    input  wire logic          res_valid,
    input  wire asr_pkg::asr_res_t res_data,
    output logic               res_ready,
    input  wire logic          idle,
    input  wire logic          cal_err,
    output asr_pkg::asr_regs_t regs,
    output logic               part_reset
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] s1_q, s2_q, s3_q;
    logic       sclk_rise, sclk_fall, din_s, sync_lo;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_q <= 3'h7;
            s2_q <= 3'h7;
            s3_q <= 3'h7;
        end else begin
            s1_q <= {sync_n, din, sclk};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign sclk_rise = s2_q[0] && !s3_q[0];
    assign sclk_fall = !s2_q[0] && s3_q[0];
    assign din_s     = s2_q[1];
    assign sync_lo   = !s2_q[2];

    // ------------------------------------------------------------
    // result buffer
    // ------------------------------------------------------------
    asr_pkg::asr_res_t head;
    logic              head_valid, pop, prst_q, prst_d;

    asr_fifo #(
        .WIDTH ($bits(asr_pkg::asr_res_t)),
        .DEPTH (asr_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .flush     (prst_q),
        .in_valid  (res_valid),
        .in_ready  (res_ready),
        .in_data   (res_data),
        .out_valid (head_valid),
        .out_ready (pop),
        .out_data  (head)
    );

    // ------------------------------------------------------------
    // serial engine and status
    // ------------------------------------------------------------
    asr_pkg::asr_state_t st_q, st_d;
    asr_pkg::asr_stat_t  stat_q, stat_d;
    asr_pkg::asr_regs_t  regs_q, regs_d;
    logic [5:0]  cnt_q, cnt_d, ones_q, ones_d, clen;
    logic [6:0]  cmd_q, cmd_d;
    logic [7:0]  win_q, win_d;
    logic [23:0] wr_q, wr_d, data_q, data_d, ld_data;
    logic [31:0] out_q, out_d;
    logic        rd_q, rd_d, continuous_read_bit_q, continuous_read_bit_d, pre_q, pre_d, dout_q, dout_d;
    logic        datsta, busy, start_cr, ref_bad;
    logic [2:0]  rs;

    function automatic logic [5:0] reg_len(input logic [2:0] sel, input logic sta);
        case (sel)
            asr_pkg::RS_STAT, asr_pkg::RS_ID, asr_pkg::RS_GPO: reg_len = asr_pkg::LEN_BYTE;
            asr_pkg::RS_DATA: reg_len = sta ? asr_pkg::LEN_WSTAT : asr_pkg::LEN_WORD;
            default:          reg_len = asr_pkg::LEN_WORD;
        endcase
    endfunction : reg_len

    assign datsta   = regs_q.mode[asr_pkg::MODE_DATSTA];
    assign clen     = reg_len(asr_pkg::RS_DATA, datsta);
    assign busy     = (st_q == asr_pkg::ST_XFER);
    assign start_cr = (st_q == asr_pkg::ST_CONTINUOUS_READ_BIT) && !stat_q.rdy && !pre_q;
    assign ref_bad  = head.ref_low && regs_q.conf[asr_pkg::CONF_REFERENCE_DETECT_ENABLE];
    assign ld_data  = ref_bad ? '1 : head.data;
    assign rs       = cmd_d[asr_pkg::CMD_RS_HI:asr_pkg::CMD_RS_LO];

    // read words are left-justified so the msb always leaves first
    function automatic logic [31:0] rd_word(input logic [2:0] sel);
        case (sel)
            asr_pkg::RS_STAT: rd_word = {stat_q, 24'h000000};
            asr_pkg::RS_MODE: rd_word = {regs_q.mode, 8'h00};
            asr_pkg::RS_CONF: rd_word = {regs_q.conf, 8'h00};
            asr_pkg::RS_DATA: rd_word = {data_q, datsta ? stat_q : 8'h00};
            asr_pkg::RS_ID:   rd_word = {ID_VALUE, 24'h000000};
            asr_pkg::RS_GPO:  rd_word = {regs_q.gpo, 24'h000000};
            asr_pkg::RS_OFFS: rd_word = {regs_q.offs, 8'h00};
            default:          rd_word = {regs_q.fsc, 8'h00};
        endcase
    endfunction : rd_word

    always_comb begin
        st_d    = st_q;
        stat_d  = stat_q;
        regs_d  = regs_q;
        cnt_d   = cnt_q;
        ones_d  = ones_q;
        cmd_d   = cmd_q;
        win_d   = win_q;
        wr_d    = wr_q;
        data_d  = data_q;
        out_d   = out_q;
        rd_d    = rd_q;
        continuous_read_bit_d = continuous_read_bit_q;
        pre_d   = pre_q;
        prst_d  = 1'b0;
        pop     = 1'b0;
        if (sclk_rise) begin
            ones_d = din_s ? ones_q + 6'h01 : 6'h00;
        end
        // result load: raise ready first, then replace the word
        if (head_valid && !busy && !start_cr) begin
            if (!pre_q) begin
                pre_d      = 1'b1;
                stat_d.rdy = 1'b1;
            end else begin
                pop           = 1'b1;
                pre_d         = 1'b0;
                data_d        = ld_data;
                stat_d.rdy    = 1'b0;
                stat_d.err    = head.clamp || ref_bad;
                stat_d.reference_missing_flag  = ref_bad;
                stat_d.parity = regs_q.mode[asr_pkg::MODE_PARITY_ENABLE_BIT] && (^ld_data);
                stat_d.chan   = head.chan;
            end
        end
        case (st_q)
            asr_pkg::ST_WEN: begin
                if (sclk_rise && !din_s) begin
                    st_d  = asr_pkg::ST_CMD;
                    cnt_d = asr_pkg::CMD_TAIL;
                end
            end
            asr_pkg::ST_CMD: begin
                if (sclk_rise) begin
                    cmd_d = {cmd_q[5:0], din_s};
                    cnt_d = cnt_q - 6'h01;
                    if (cnt_q == 6'h01) begin
                        rd_d  = cmd_d[asr_pkg::CMD_RW];
                        cnt_d = reg_len(rs, datsta);
                        out_d = rd_word(rs);
                        st_d  = asr_pkg::ST_XFER;
                        if (rd_d && rs == asr_pkg::RS_DATA && cmd_d[asr_pkg::CMD_CONTINUOUS_READ_BIT]) begin
                            continuous_read_bit_d = 1'b1;
                            rd_d    = 1'b0;
                            st_d    = asr_pkg::ST_CONTINUOUS_READ_BIT;
                        end else if (!rd_d && rs == asr_pkg::RS_STAT) begin
                            st_d = asr_pkg::ST_WEN;
                        end
                    end
                end
            end
            asr_pkg::ST_CONTINUOUS_READ_BIT: begin
                if (start_cr) begin
                    out_d = rd_word(asr_pkg::RS_DATA);
                    cnt_d = clen;
                    rd_d  = 1'b1;
                    st_d  = asr_pkg::ST_XFER;
                end
            end
            default: begin
                // the msb already stands before the first fall, so that fall keeps it
                if (sclk_fall && rd_q
                    && cnt_q != reg_len(cmd_q[asr_pkg::CMD_RS_HI:asr_pkg::CMD_RS_LO], datsta)) begin
                    out_d = {out_q[30:0], 1'b0};
                end
                if (sclk_rise) begin
                    wr_d  = {wr_q[22:0], din_s};
                    win_d = {win_q[6:0], din_s};
                    cnt_d = cnt_q - 6'h01;
                    // exit command is judged on the first byte of a result read
                    if (continuous_read_bit_q && cnt_q == clen - asr_pkg::CMD_TAIL
                        && win_d == asr_pkg::EXIT_CONTINUOUS_READ_BIT) begin
                        continuous_read_bit_d = 1'b0;
                        rd_d    = 1'b0;
                        st_d    = asr_pkg::ST_WEN;
                    end else if (cnt_q == 6'h01) begin
                        rd_d = 1'b0;
                        st_d = continuous_read_bit_q ? asr_pkg::ST_CONTINUOUS_READ_BIT : asr_pkg::ST_WEN;
                        if (rd_q && cmd_q[asr_pkg::CMD_RS_HI:asr_pkg::CMD_RS_LO] == asr_pkg::RS_DATA
                            || continuous_read_bit_q) begin
                            stat_d.rdy = 1'b1;
                        end
                        if (!rd_q) begin
                            case (cmd_q[asr_pkg::CMD_RS_HI:asr_pkg::CMD_RS_LO])
                                asr_pkg::RS_MODE: regs_d.mode = wr_d;
                                asr_pkg::RS_CONF: regs_d.conf = wr_d;
                                asr_pkg::RS_GPO:  regs_d.gpo  = wr_d[7:0];
                                asr_pkg::RS_OFFS: regs_d.offs = wr_d;
                                asr_pkg::RS_FSC:  regs_d.fsc  = wr_d;
                                default:          regs_d      = regs_q;       // read-only ignored
                            endcase
                        end
                    end
                end
            end
        endcase
        // set sources override a same-cycle clear
        if (sync_lo || idle) begin
            stat_d.rdy = 1'b1;
        end
        if (cal_err) begin
            stat_d.err = 1'b1;
        end
        if (sclk_rise && din_s && ones_q == asr_pkg::ONES_RESET - 6'h01) begin
            st_d    = asr_pkg::ST_WEN;
            stat_d  = asr_pkg::asr_stat_t'(asr_pkg::STAT_RST);
            regs_d  = '{asr_pkg::MODE_RST, asr_pkg::CONF_RST, asr_pkg::OFFS_RST,
                        FSC_RST, asr_pkg::GPO_RST};
            continuous_read_bit_d = 1'b0;
            rd_d    = 1'b0;
            pre_d   = 1'b0;
            pop     = 1'b0;
            data_d  = '0;
            ones_d  = '0;
            prst_d  = 1'b1;
        end
        // pin shows shifted data during a read, otherwise the ready flag
        dout_d = (st_d == asr_pkg::ST_XFER && rd_d) ? out_d[31] : stat_d.rdy;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q    <= asr_pkg::ST_WEN;
            stat_q  <= asr_pkg::asr_stat_t'(asr_pkg::STAT_RST);
            regs_q  <= '{asr_pkg::MODE_RST, asr_pkg::CONF_RST, asr_pkg::OFFS_RST,
                         FSC_RST, asr_pkg::GPO_RST};
            cnt_q   <= '0;
            ones_q  <= '0;
            cmd_q   <= '0;
            win_q   <= '0;
            wr_q    <= '0;
            data_q  <= '0;
            out_q   <= '0;
            rd_q    <= 1'b0;
            continuous_read_bit_q <= 1'b0;
            pre_q   <= 1'b0;
            dout_q  <= 1'b1;
            prst_q  <= 1'b0;
        end else begin
            st_q    <= st_d;
            stat_q  <= stat_d;
            regs_q  <= regs_d;
            cnt_q   <= cnt_d;
            ones_q  <= ones_d;
            cmd_q   <= cmd_d;
            win_q   <= win_d;
            wr_q    <= wr_d;
            data_q  <= data_d;
            out_q   <= out_d;
            rd_q    <= rd_d;
            continuous_read_bit_q <= continuous_read_bit_d;
            pre_q   <= pre_d;
            dout_q  <= dout_d;
            prst_q  <= prst_d;
        end
    end

    assign dout_rdy   = dout_q;
    assign regs       = regs_q;
    assign part_reset = prst_q;
endmodule : asr_top

/* File: common/asr_pkg.sv */
// Behaviour
// - direction one makes next transfer a read
// - command bits five to three select register
// - select zero: write command, read status
// - select 011 reads result, 24 or 32
// - other select codes map fixed-size registers
// - continuous read shifts results without commands
// - continuous read watches input; 40 ones reset
// - status is 8 bits, read only, 0x80
// - status msb first: ready, error, ref, parity, tag
// - ready clears on result, sets on events
// - output pin also shows end of conversion
// - error follows clamped result, with ready
// - error also sets on calibration faults
// - missing reference flag sets, clamps all ones
// - parity flag shows odd ones in result
// - channel tag belongs to the stored result
// - every transaction starts with command write
// - first command bit zero before loading
// - direction zero makes next transfer a write
// - 40 ones on input resets whole part
package asr_pkg;
    localparam logic [23:0] MODE_RST    = 24'h080060;
    localparam logic [23:0] CONF_RST    = 24'h000117;
    localparam logic [23:0] OFFS_RST    = 24'h800000;
    localparam logic [7:0]  GPO_RST     = 8'h00;
    localparam logic [7:0]  STAT_RST    = 8'h80;
    localparam logic [7:0]  EXIT_CONTINUOUS_READ_BIT  = 8'h58;
    localparam logic [2:0]  RS_STAT     = 3'h0;
    localparam logic [2:0]  RS_MODE     = 3'h1;
    localparam logic [2:0]  RS_CONF     = 3'h2;
    localparam logic [2:0]  RS_DATA     = 3'h3;
    localparam logic [2:0]  RS_ID       = 3'h4;
    localparam logic [2:0]  RS_GPO      = 3'h5;
    localparam logic [2:0]  RS_OFFS     = 3'h6;
    localparam logic [2:0]  RS_FSC      = 3'h7;
    localparam int          CMD_RW      = 6;
    localparam int          CMD_RS_HI   = 5;
    localparam int          CMD_RS_LO   = 3;
    localparam int          CMD_CONTINUOUS_READ_BIT   = 2;
    localparam int          MODE_DATSTA = 20;
    localparam int          MODE_PARITY_ENABLE_BIT  = 13;
    localparam int          CONF_REFERENCE_DETECT_ENABLE = 6;
    localparam logic [5:0]  ONES_RESET  = 6'h28;
    localparam logic [5:0]  CMD_TAIL    = 6'h07;
    localparam logic [5:0]  LEN_BYTE    = 6'h08;
    localparam logic [5:0]  LEN_WORD    = 6'h18;
    localparam logic [5:0]  LEN_WSTAT   = 6'h20;
    localparam int          FIFO_DEPTH  = 8;

    typedef enum logic [1:0] {ST_WEN, ST_CMD, ST_XFER, ST_CONTINUOUS_READ_BIT} asr_state_t;

    typedef struct packed {
        logic       rdy;
        logic       err;
        logic       reference_missing_flag;
        logic       parity;
        logic [3:0] chan;
    } asr_stat_t;

    typedef struct packed {
        logic [23:0] data;
        logic [3:0]  chan;
        logic        clamp;
        logic        ref_low;
    } asr_res_t;

    typedef struct packed {
        logic [23:0] mode;
        logic [23:0] conf;
        logic [23:0] offs;
        logic [23:0] fsc;
        logic [7:0]  gpo;
    } asr_regs_t;
endpackage : asr_pkg

/* File: tb/asr_monitor.sv */
`timescale 1ns/1ps

module asr_monitor #(
    parameter logic [7:0]  ID_VALUE = 8'h02,
    parameter logic [23:0] FSC_RST  = 24'h500000
) (
    input wire logic               clk,
    input wire logic               nrst,
    input wire logic               sclk,
    input wire logic               din,
    input wire logic               sync_n,
    input wire logic               dout_rdy,
    input wire logic               res_valid,
    input wire asr_pkg::asr_res_t  res_data,
    input wire logic               res_ready,
    input wire logic               idle,
    input wire logic               cal_err,
    input wire asr_pkg::asr_regs_t regs,
    input wire logic               part_reset
);
    logic [5:0] quiet_q;
    logic [5:0] quiet_d;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ----------------------------------------
    // sclk parked high this long: no frame runs
    // ----------------------------------------
    always_comb quiet_d = !sclk ? 6'h00 : quiet_q + {5'h0, quiet_q != 6'h3f};
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) quiet_q <= 6'h00;
        else quiet_q <= quiet_d;
    end

    chk_reset_pulse: assert property (part_reset |=> !part_reset)
        else $error("part reset pulse too long");
    chk_reset_regs: assert property (part_reset |-> ##[0:1] (regs.mode == asr_pkg::MODE_RST
        && regs.conf == asr_pkg::CONF_RST && regs.fsc == FSC_RST && regs.gpo == asr_pkg::GPO_RST))
        else $error("registers not back at reset values");
    chk_flush_ready: assert property (part_reset |-> ##[1:3] res_ready)
        else $error("buffer not emptied by part reset");
    chk_reset_rdy: assert property (part_reset |-> ##[1:3] dout_rdy)
        else $error("ready pin low after part reset");
    chk_regs_cause: assert property (!$stable(regs) |-> part_reset || $past(part_reset) || $past(sclk))
        else $error("registers changed without a serial clock rise");
    chk_sync_ready: assert property (quiet_q >= 6'h14 && !sync_n && !$past(sync_n) |-> ##[0:3] dout_rdy)
        else $error("ready pin low while sync held low");
    chk_idle_ready: assert property (quiet_q >= 6'h14 && idle && $past(idle) |-> ##[0:3] dout_rdy)
        else $error("ready pin low while idle");
    chk_pin_result: assert property (quiet_q >= 6'h14 && res_valid && res_ready && sync_n && !idle
        |-> ##[1:8] !dout_rdy)
        else $error("new result not shown on ready pin");
endmodule : asr_monitor

bind asr_top asr_monitor #(.ID_VALUE(ID_VALUE), .FSC_RST(FSC_RST)) u_mon (
    .clk(clk), .nrst(nrst), .sclk(sclk), .din(din), .sync_n(sync_n), .dout_rdy(dout_rdy),
    .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready), .idle(idle),
    .cal_err(cal_err), .regs(regs), .part_reset(part_reset)
);

/* File: tb/asr_host.sv */
`timescale 1ns/1ps

module asr_host (
    input  wire logic clk,
    input  wire logic dout_rdy,
    output logic      sclk,
    output logic      din
);
    initial begin
        sclk = 1'b1;
        din  = 1'b0;
    end

    // din moves with sclk low, dout taken once the rise has settled
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = 32'h0;
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge clk);
            sclk = 1'b0;
            din  = tx[i];
            repeat (4) @(negedge clk);
            sclk = 1'b1;
            repeat (2) @(negedge clk);
            rx = {rx[30:0], dout_rdy};
            @(negedge clk);
        end
        din = 1'b0; // parked low so stray ones never add up to a reset
    endtask : xfer
endmodule : asr_host

/* File: tb/asr_top_tb.sv */
`timescale 1ns/1ps

module asr_top_tb;
    localparam logic [7:0]  ID  = 8'h5a; // arbitrary value
    localparam logic [23:0] FSC = 24'h500000;
    logic               clk, nrst, sclk, din, sync_n, dout_rdy;
    logic               res_valid, res_ready, idle, cal_err, part_reset;
    asr_pkg::asr_res_t  res_data;
    asr_pkg::asr_regs_t regs;
    logic [31:0]        m_reg [8];
    logic [7:0]         m_st;
    logic [23:0]        m_dat;
    logic [31:0]        lf, rx, ex;
    int                 failures = 0;
    int                 checked = 0;
    int                 cyc = 0;

    asr_top #(.ID_VALUE(ID), .FSC_RST(FSC)) uut (
        .clk(clk), .nrst(nrst), .sclk(sclk), .din(din), .sync_n(sync_n), .dout_rdy(dout_rdy),
        .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready), .idle(idle),
        .cal_err(cal_err), .regs(regs), .part_reset(part_reset)
    );
    asr_host host (.clk(clk), .dout_rdy(dout_rdy), .sclk(sclk), .din(din));

    // ----------------------------------------
    // model and helpers
    // ----------------------------------------
    function automatic logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nx

    function automatic int len(input logic [2:0] r);
        if (r == 3'h3) return m_reg[1][asr_pkg::MODE_DATSTA] ? 32 : 24;
        return (r == 3'h0 || r[2:1] == 2'b10) ? 8 : 24;
    endfunction : len

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("ERROR at %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic test_done;
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    task automatic mreset;
        m_reg[1] = 32'(asr_pkg::MODE_RST);
        m_reg[2] = 32'(asr_pkg::CONF_RST);
        m_reg[4] = 32'(ID);
        m_reg[5] = 32'(asr_pkg::GPO_RST);
        m_reg[6] = 32'(asr_pkg::OFFS_RST);
        m_reg[7] = 32'(FSC);
        m_st     = asr_pkg::STAT_RST;
    endtask : mreset

    task automatic rd(input logic [2:0] r, input logic [31:0] e);
        host.xfer({24'h0, 2'b01, r, 3'b000}, 8, rx);
        host.xfer(32'h0, len(r), rx);
        chk(rx, e);
    endtask : rd

    task automatic wr(input logic [2:0] r, input logic [31:0] v);
        m_reg[r] = (len(r) == 8) ? v & 32'hff : v & 32'hffffff;
        host.xfer({24'h0, 2'b00, r, 3'b000}, 8, rx);
        host.xfer(m_reg[r], len(r), rx);
    endtask : wr

    task automatic push(input logic [23:0] d, input logic [3:0] ch, input logic cl, input logic rl);
        logic rb;
        @(negedge clk);
        res_data  = '{data: d, chan: ch, clamp: cl, ref_low: rl};
        res_valid = 1'b1;
        while (res_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        rb    = rl & m_reg[2][asr_pkg::CONF_REFERENCE_DETECT_ENABLE];
        m_dat = rb ? 24'hffffff : d;
        m_st  = {1'b0, cl | rb, rb, m_reg[1][asr_pkg::MODE_PARITY_ENABLE_BIT] & ^m_dat, ch};
    endtask : push

    task automatic stop;
        @(negedge clk);
        res_valid = 1'b0;
    endtask : stop

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            test_done;
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        nrst = 1'b0; sync_n = 1'b1; idle = 1'b0; cal_err = 1'b0;
        res_valid = 1'b0; res_data = '0; lf = 32'hd1194b38;
        mreset;
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        rd(3'h0, {24'h0, m_st});
        for (int r = 1; r < 8; r++) begin
            if (r == 3) continue;
            rd(r[2:0], m_reg[r]);
            if (r == 4) continue;
            lf = nx(lf);
            wr(r[2:0], lf);
            rd(r[2:0], m_reg[r]);
        end
        chk(32'(regs.offs), m_reg[6]);
        host.xfer(32'h7, 3, rx);
        rd(3'h0, {24'h0, m_st}); // leading ones skipped
        wr(3'h1, 32'h182060); // status appended with parity
        wr(3'h2, lf | 32'h40);
        for (int k = 0; k < 4; k++) begin
            lf = nx(lf);
            repeat (24) @(negedge clk);
            push(lf[23:0], lf[27:24], k[0], k[1]);
            stop;
            repeat (8) @(negedge clk);
            chk(32'(dout_rdy), 32'h0);
            rd(3'h0, {24'h0, m_st});
            rd(3'h3, {m_dat, m_st});
            m_st[7] = 1'b1;
            rd(3'h0, {24'h0, m_st});
        end
        cal_err = 1'b1;
        repeat (4) @(negedge clk);
        cal_err = 1'b0;
        m_st[6] = 1'b1;
        rd(3'h0, {24'h0, m_st});
        for (int j = 0; j < 2; j++) begin
            sync_n = j[0];
            idle = j[0];
            repeat (24) @(negedge clk);
            lf = nx(lf);
            push(lf[23:0], lf[27:24], 1'b0, 1'b0);
            stop;
            repeat (8) @(negedge clk);
            chk(32'(dout_rdy), 32'h1);
            sync_n = 1'b1;
            idle = 1'b0;
            m_st[7] = 1'b1;
            rd(3'h0, {24'h0, m_st});
        end
        ex = {24'h0, m_st};
        fork
            rd(3'h0, ex);
            begin
                repeat (90) @(negedge clk);
                for (int i = 0; i < asr_pkg::FIFO_DEPTH; i++) begin
                    lf = nx(lf);
                    push(lf[23:0], lf[27:24], lf[28], lf[29]);
                end
                stop;
                repeat (2) @(negedge clk);
                chk(32'(res_ready), 32'h0); // loads wait out the transfer
            end
        join
        repeat (40) @(negedge clk);
        rd(3'h3, {m_dat, m_st}); // newest result kept
        host.xfer(32'h5c, 8, rx);
        for (int j = 0; j < 2; j++) begin
            lf = nx(lf);
            push({1'b0, lf[22:0]}, lf[27:24], 1'b0, 1'b0);
            stop;
            for (int t = 0; t < 40 && dout_rdy !== 1'b0; t++) @(negedge clk);
            host.xfer(j ? 32'(asr_pkg::EXIT_CONTINUOUS_READ_BIT) : 32'h0, j ? 8 : len(3'h3), rx);
            chk(rx, j ? 32'(m_dat[23:16]) : {m_dat, m_st});
        end
        rd(3'h1, m_reg[1]);
        host.xfer(32'hffffffff, 32, rx);
        host.xfer(32'hff, 8, rx);
        mreset;
        repeat (4) @(negedge clk);
        chk(32'(regs.mode), m_reg[1]);
        rd(3'h0, {24'h0, m_st});
        rd(3'h6, m_reg[6]);
        test_done;
    end
endmodule : asr_top_tb
